// File: hdl/serial_port_pkg.sv
/*
  Constants and types for the serial port with break and clocked master transmit.
  Assumes an APB master with 32-bit data and a 100 MHz system clock.
*/
// Notes on behaviour
// - Wake enable keeps the receiver idle; a wake event sets receive_flag.
// - Wake enable self-clears on the next rising edge; data read clears receive_flag.
// - A break is start bit, twelve zero bits, stop bit.
// - Break request plus transmit enable sends a break, ignoring the written byte.
// - Break request clears itself after the break stop bit; buffered byte follows.
// - shift_register_empty behaves the same during a break.
// - After wake, flag on the first of two line transitions, then next byte and flag again.
// - Master mode selected by clock_source_master; clocked mode is half duplex.
// - Clocked mode with port enable turns pins into shift clock and data.
// - Master drives the shift clock; clock_idle_polarity picks its idle level.
// - Shift register reloads only after the last bit and only if a word waits.
// - Buffer to shift register move takes one cycle, then the empty flag sets.
// - Empty flag ignores interrupt enable; only a buffer write clears it.
// - shift_register_empty is read only, no interrupt, shift register hidden.
// - A wake event is a falling edge on the receive line.
// - wake_on_edge_enable sits at bit 1 of the baud control register.
package serial_port_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] BAUD_OFFSET = 8'h08;
  localparam logic [7:0] TX_DATA_OFFSET = 8'h0C;
  localparam logic [7:0] RX_DATA_OFFSET = 8'h10;
  localparam logic [7:0] BAUD_CTRL_OFFSET = 8'h14;
  localparam int CTRL_WIDTH = 9;
  localparam int WAKE_BIT = 1;
  localparam int SRE_BIT = 0;
  localparam int TBE_BIT = 1;
  localparam int RFLAG_BIT = 2;
  localparam int RIDLE_BIT = 3;

  // ==========================================================================
  // Frame constants and reset values
  localparam logic [3:0] BREAK_BITS = 4'hE;
  localparam logic [13:0] BREAK_FRAME = 14'h2000;
  localparam logic [3:0] ASYNC_BITS = 4'hA;
  localparam logic [3:0] SYNC_BITS = 4'h8;
  localparam logic [3:0] RX_LAST_BIT = 4'h7;
  localparam logic [2:0] RX_SYNC_RESET = 3'h7;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic wide_baud_divisor;
    logic clock_idle_polarity;
    logic transmit_ninth_bit;
    logic nine_bit_transmit;
    logic break_send_request;
    logic transmit_enable;
    logic clock_source_master;
    logic clocked_mode_select;
    logic serial_port_enable;
  } ctrl_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_LOAD = 3'b010,
    TX_SHIFT = 3'b100
  } tx_state_type;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA = 4'b0100,
    RX_STOP = 4'b1000
  } rx_state_type;

endpackage : serial_port_pkg

// File: hdl/serial_port.sv
/*
  Serial port core: APB registers, asynchronous transmit with break, clocked
  master transmit, wake-on-edge and a simple asynchronous receiver.
  Assumes pins are resolved outside from the output enables.
*/
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module serial_port
  import serial_port_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // APB slave
  input wire apb_req_type i_apb,
  output apb_rsp_type o_apb,
  // Transmit pin, shift clock in clocked mode
  output logic o_tx_ck_out,
  output logic o_tx_ck_oe,
  // Receive pin, data line in clocked mode
  input wire logic i_receive_data_pin_in,
  output logic o_receive_data_pin_out,
  output logic o_receive_data_pin_oe
);

  // ==========================================================================
  // State
  typedef struct packed {
    ctrl_type ctrl;
    logic wake_on_edge_enable;
    logic [15:0] div;
    logic [7:0] txbuf;
    logic buf_full;
    tx_state_type tx;
    logic [13:0] shreg;
    logic [3:0] bits;
    logic [15:0] bcnt;
    logic half;
    logic brk;
    logic tx_pin;
    logic ck_oe;
    logic dt_out;
    logic dt_oe;
    logic [2:0] rxs;
    logic woke;
    logic rflag;
    rx_state_type rx;
    logic [15:0] rcnt;
    logic [3:0] rbits;
    logic [7:0] rsh;
    logic [7:0] rdata;
    apb_rsp_type rsp;
  } state_type;

  state_type q;
  state_type d;
  logic [15:0] eff_div;
  logic wr_acc;
  logic rd_acc;
  logic fall;
  logic rise;
  logic tx_ok;
  logic shift_done;

  // ==========================================================================
  // Next state
  always_comb begin
    d = q;
    eff_div = q.ctrl.wide_baud_divisor ? q.div : {8'h00, q.div[7:0]};
    wr_acc = i_apb.psel & i_apb.penable & q.rsp.pready & i_apb.pwrite;
    rd_acc = i_apb.psel & i_apb.penable & q.rsp.pready & ~i_apb.pwrite;
    fall = q.rxs[2] & ~q.rxs[1];
    rise = ~q.rxs[2] & q.rxs[1];
    tx_ok = q.ctrl.serial_port_enable & q.ctrl.transmit_enable &
            (~q.ctrl.clocked_mode_select | q.ctrl.clock_source_master);
    shift_done = 1'b0;
    d.rxs = {q.rxs[1], q.rxs[0], i_receive_data_pin_in};

    // Transmitter runs before the bus writes so a buffer write in the
    // transfer cycle refills the buffer instead of being lost.
    unique case (q.tx)
      TX_IDLE: begin
        if (q.buf_full && tx_ok) begin
          d.tx = TX_LOAD;
        end
      end
      TX_LOAD: begin
        d.buf_full = 1'b0;
        d.brk = q.ctrl.break_send_request & q.ctrl.transmit_enable;
        d.half = 1'b0;
        d.bcnt = eff_div;
        d.tx = TX_SHIFT;
        if (d.brk) begin
          d.shreg = BREAK_FRAME;
          d.bits = BREAK_BITS;
        end else if (q.ctrl.clocked_mode_select) begin
          d.shreg = {5'h00, q.ctrl.transmit_ninth_bit, q.txbuf};
          d.bits = SYNC_BITS + {3'h0, q.ctrl.nine_bit_transmit};
        end else if (q.ctrl.nine_bit_transmit) begin
          d.shreg = {3'h0, 1'b1, q.ctrl.transmit_ninth_bit, q.txbuf, 1'b0};
          d.bits = ASYNC_BITS + 4'h1;
        end else begin
          d.shreg = {4'h0, 1'b1, q.txbuf, 1'b0};
          d.bits = ASYNC_BITS;
        end
      end
      TX_SHIFT: begin
        if (!q.ctrl.transmit_enable) begin
          d.tx = TX_IDLE;
          d.brk = 1'b0;
        end else if (q.bcnt != 16'h0000) begin
          d.bcnt = q.bcnt - 16'h0001;
        end else begin
          d.bcnt = eff_div;
          if (q.ctrl.clocked_mode_select && !q.half) begin
            d.half = 1'b1;
          end else begin
            d.half = 1'b0;
            d.shreg = {1'b0, q.shreg[13:1]};
            d.bits = q.bits - 4'h1;
            if (q.bits == 4'h1) begin
              shift_done = 1'b1;
              d.brk = 1'b0;
              d.tx = (q.buf_full && tx_ok) ? TX_LOAD : TX_IDLE;
            end
          end
        end
      end
    endcase

    // APB: the setup cycle decodes and latches the answer, so every access
    // completes with pready high in its first access cycle.
    d.rsp.pready = i_apb.psel & ~i_apb.penable;
    if (i_apb.psel && !i_apb.penable) begin
      d.rsp.prdata = 32'h0000_0000;
      d.rsp.pslverr = 1'b0;
      case (i_apb.paddr)
        CTRL_OFFSET: d.rsp.prdata[CTRL_WIDTH-1:0] = q.ctrl;
        STATUS_OFFSET: begin
          d.rsp.prdata[SRE_BIT] = (q.tx == TX_IDLE);
          d.rsp.prdata[TBE_BIT] = ~q.buf_full;
          d.rsp.prdata[RFLAG_BIT] = q.rflag;
          d.rsp.prdata[RIDLE_BIT] = (q.rx == RX_IDLE) & ~q.wake_on_edge_enable;
        end
        BAUD_OFFSET: d.rsp.prdata[15:0] = q.div;
        TX_DATA_OFFSET: d.rsp.prdata[7:0] = q.txbuf;
        RX_DATA_OFFSET: d.rsp.prdata[7:0] = q.rdata;
        BAUD_CTRL_OFFSET: d.rsp.prdata[WAKE_BIT] = q.wake_on_edge_enable;
        default: d.rsp.pslverr = 1'b1;
      endcase
    end
    if (wr_acc) begin
      case (i_apb.paddr)
        CTRL_OFFSET: d.ctrl = ctrl_type'(i_apb.pwdata[CTRL_WIDTH-1:0]);
        BAUD_OFFSET: d.div = i_apb.pwdata[15:0];
        BAUD_CTRL_OFFSET: d.wake_on_edge_enable = i_apb.pwdata[WAKE_BIT];
        TX_DATA_OFFSET: begin
          d.txbuf = i_apb.pwdata[7:0];
          d.buf_full = 1'b1;
        end
        default: ;
      endcase
    end
    if (rd_acc && i_apb.paddr == RX_DATA_OFFSET) begin
      d.rflag = 1'b0;
    end

    // The hardware clear of the break request wins over a control write in
    // the same cycle, so a rewrite cannot resend the break by accident.
    if (shift_done && q.brk) begin
      d.ctrl.break_send_request = 1'b0;
    end

    // Wake-on-edge holds the receiver idle until the line rises again.
    if (q.wake_on_edge_enable) begin
      d.rx = RX_IDLE;
      if (!q.woke && fall) begin
        d.rflag = 1'b1;
        d.woke = 1'b1;
      end else if (q.woke && rise) begin
        d.wake_on_edge_enable = 1'b0;
        d.woke = 1'b0;
      end
    end else if (!q.ctrl.serial_port_enable || q.ctrl.clocked_mode_select) begin
      d.woke = 1'b0;
      d.rx = RX_IDLE;
    end else begin
      d.woke = 1'b0;
      unique case (q.rx)
        RX_IDLE: begin
          if (fall) begin
            d.rx = RX_START;
            d.rcnt = {1'b0, eff_div[15:1]};
          end
        end
        RX_START: begin
          if (q.rcnt != 16'h0000) begin
            d.rcnt = q.rcnt - 16'h0001;
          end else begin
            d.rx = q.rxs[1] ? RX_IDLE : RX_DATA;
            d.rcnt = eff_div;
            d.rbits = 4'h0;
          end
        end
        RX_DATA: begin
          if (q.rcnt != 16'h0000) begin
            d.rcnt = q.rcnt - 16'h0001;
          end else begin
            d.rsh = {q.rxs[1], q.rsh[7:1]};
            d.rcnt = eff_div;
            d.rbits = q.rbits + 4'h1;
            if (q.rbits == RX_LAST_BIT) begin
              d.rx = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (q.rcnt != 16'h0000) begin
            d.rcnt = q.rcnt - 16'h0001;
          end else begin
            d.rdata = q.rsh;
            d.rflag = 1'b1;
            d.rx = RX_IDLE;
          end
        end
      endcase
    end

    // Pins follow the next state so they leave flip-flops in step with it.
    d.ck_oe = d.ctrl.serial_port_enable &
              (~d.ctrl.clocked_mode_select | d.ctrl.clock_source_master);
    d.dt_oe = d.ctrl.serial_port_enable & d.ctrl.clocked_mode_select &
              d.ctrl.clock_source_master & (d.tx == TX_SHIFT);
    d.dt_out = d.shreg[0];
    if (d.ctrl.clocked_mode_select) begin
      d.tx_pin = d.ctrl.clock_idle_polarity ^ ((d.tx == TX_SHIFT) & d.half);
    end else begin
      d.tx_pin = (d.tx == TX_SHIFT) ? d.shreg[0] : 1'b1;
    end

    if (i_reset) begin
      d = '0;
      d.tx = TX_IDLE;
      d.rx = RX_IDLE;
      d.rxs = RX_SYNC_RESET;
      d.tx_pin = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    q <= d;
  end

  assign o_apb = q.rsp;
  assign o_tx_ck_out = q.tx_pin;
  assign o_tx_ck_oe = q.ck_oe;
  assign o_receive_data_pin_out = q.dt_out;
  assign o_receive_data_pin_oe = q.dt_oe;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  sequence s_wake_fall;
    q.wake_on_edge_enable && !q.woke && fall;
  endsequence

  sequence s_wake_rise;
    q.wake_on_edge_enable && q.woke && rise;
  endsequence

  sequence s_load_break;
    q.tx == TX_LOAD && q.ctrl.break_send_request && q.ctrl.transmit_enable;
  endsequence

  chk_wake_sets_flag: assert property (s_wake_fall |=> q.rflag && q.woke)
    else $error("wake edge did not raise receive flag");

  chk_wake_self_clear: assert property (s_wake_rise |=> !q.wake_on_edge_enable)
    else $error("wake enable not cleared on rising edge");

  chk_rx_held_idle: assert property (
    q.wake_on_edge_enable |=> q.rx == RX_IDLE)
    else $error("receiver left idle while wake enabled");

  chk_break_frame: assert property (
    s_load_break |=> q.shreg == BREAK_FRAME && q.bits == BREAK_BITS && q.brk)
    else $error("break frame not loaded");

  chk_break_clears: assert property (
    shift_done && q.brk |=> !q.ctrl.break_send_request)
    else $error("break request not cleared after stop bit");

  chk_load_one_cycle: assert property (
    q.tx == TX_LOAD && !wr_acc |=> !q.buf_full && q.tx == TX_SHIFT)
    else $error("buffer transfer did not finish in one cycle");

  chk_flag_held: assert property (
    !q.buf_full && !wr_acc |=> !q.buf_full)
    else $error("buffer empty flag cleared without a write");

  chk_no_early_reload: assert property (
    q.tx == TX_SHIFT && !shift_done && q.ctrl.transmit_enable |=> q.tx == TX_SHIFT)
    else $error("shift register left before last bit");

  chk_busy_after_load: assert property (
    q.tx == TX_LOAD |=> q.tx != TX_IDLE ##1 q.tx != TX_IDLE)
    else $error("empty indication during a frame");

  chk_clock_idle: assert property (
    (q.ctrl.clocked_mode_select && q.tx == TX_IDLE && $stable(q.ctrl))[*2]
    |-> q.tx_pin == q.ctrl.clock_idle_polarity)
    else $error("shift clock not at idle level");

  chk_half_duplex: assert property (
    q.ctrl.clocked_mode_select && q.tx == TX_SHIFT |-> q.rx == RX_IDLE)
    else $error("reception during clocked transmit");

  chk_ninth_last: assert property (
    q.tx == TX_LOAD && !q.brk && q.ctrl.clocked_mode_select &&
    q.ctrl.nine_bit_transmit && !q.ctrl.break_send_request
    |=> q.bits == 4'h9 && q.shreg[8] == $past(q.ctrl.transmit_ninth_bit))
    else $error("ninth bit not placed after data");

  chk_read_clears: assert property (
    rd_acc && i_apb.paddr == RX_DATA_OFFSET && !q.wake_on_edge_enable &&
    q.rx != RX_STOP |=> !q.rflag)
    else $error("receive data read left the flag set");

  chk_clock_active: assert property (
    q.ctrl.clocked_mode_select && q.tx == TX_SHIFT && q.half
    |-> q.tx_pin != q.ctrl.clock_idle_polarity)
    else $error("shift clock not at active level");

  chk_data_driver: assert property (
    q.dt_oe |-> q.ctrl.serial_port_enable && q.ctrl.clocked_mode_select &&
    q.ctrl.clock_source_master && q.tx == TX_SHIFT)
    else $error("data pin driven outside clocked master transmit");

  chk_break_zeros: assert property (
    q.brk && q.tx == TX_SHIFT && q.bits > 4'h1 && !q.ctrl.clocked_mode_select
    |-> !q.tx_pin)
    else $error("break sent a one before its stop bit");

  chk_rx_off_clocked: assert property (
    q.ctrl.clocked_mode_select |=> q.rx == RX_IDLE)
    else $error("receiver active in clocked mode");

  chk_reload_next: assert property (
    shift_done && q.buf_full && tx_ok |=> q.tx == TX_LOAD)
    else $error("waiting word not moved after the last bit");

endmodule : serial_port

// File: tb/serial_peer.sv
/*
  Far-side peer of the serial port: drives the pulled-up receive line and
  captures frames from the transmit pin, asynchronous or clocked.
  Assumes the bench resolves the data wire from the output enable.
*/
`timescale 1ns/1ps
module serial_peer (
  // Clock
  input wire logic i_clk,
  // Lines seen from the port
  input wire logic i_line,
  input wire logic i_dt,
  input wire logic i_pol,
  // Line driven towards the port
  output logic o_rx
);
  // ==========================================================================
  // Line driver and capture
  int bit_clks = 16;

  initial o_rx = 1'b1;

  // Holds the line for n link periods of 80 ns; a long n models a slow peer.
  task automatic hold(input logic b, input int n);
    o_rx <= b;
    repeat (n * 8) @(posedge i_clk);
  endtask : hold

  // Samples in mid-bit, so one clock of reload gap between frames is harmless.
  task automatic catch_async(input int n, output logic [13:0] v);
    v = '0;
    @(negedge i_line);
    repeat (bit_clks / 2) @(posedge i_clk);
    for (int i = 0; i < n; i++) begin
      v[i] = i_line;
      if (i < n - 1) repeat (bit_clks) @(posedge i_clk);
    end
  endtask : catch_async

  task automatic catch_sync(input int n, output logic [8:0] v);
    v = '0;
    for (int i = 0; i < n; i++) begin
      if (i_pol) @(negedge i_line);
      else @(posedge i_line);
      v[i] = i_dt;
    end
  endtask : catch_sync
endmodule : serial_peer

// File: tb/serial_break_and_sync_master_tx_bench.sv
/*
  Bench for the serial port: wake on edge, break and sync, clocked transmit.
  Assumes the package register map and a pulled-up receive line.
*/
`timescale 1ns/1ps
module serial_break_and_sync_master_tx_bench;
  import serial_port_pkg::*;
  // ==========================================================================
  // Signals
  logic i_clk;
  logic i_reset;
  apb_req_type req;
  apb_rsp_type rsp;
  logic ck_out, ck_oe, dt_out, dt_oe, peer_rx, pol, err, dt_wire;
  logic [31:0] rd;
  logic [13:0] fa;
  logic [8:0] fs;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;

  assign dt_wire = dt_oe ? dt_out : peer_rx;

  serial_port u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_apb(req), .o_apb(rsp),
    .o_tx_ck_out(ck_out), .o_tx_ck_oe(ck_oe), .i_receive_data_pin_in(dt_wire),
    .o_receive_data_pin_out(dt_out), .o_receive_data_pin_oe(dt_oe));
  serial_peer u_peer (.i_clk(i_clk), .i_line(ck_out), .i_dt(dt_wire), .i_pol(pol),
    .o_rx(peer_rx));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge i_clk);
    req.penable <= 1'b1;
    do @(posedge i_clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge i_clk);
  endtask : apb

  task automatic results;
    $display("Checks %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    chk("pins at reset", 32'h1, {30'h0, ck_oe, ck_out});
    apb(1'b0, CTRL_OFFSET, '0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, STATUS_OFFSET, '0);
    chk("status reset", 32'hB, rd & 32'hF);
    apb(1'b0, 8'h18, '0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
  endtask : t_reset

  task automatic t_wake;
    apb(1'b1, CTRL_OFFSET, 32'h1);
    apb(1'b0, STATUS_OFFSET, '0);
    chk("receiver idle", 32'h8, rd & 32'hC);
    apb(1'b1, BAUD_CTRL_OFFSET, 32'h2);
    apb(1'b0, BAUD_CTRL_OFFSET, '0);
    chk("wake set", 32'h2, rd);
    u_peer.hold(1'b0, 2);
    apb(1'b0, STATUS_OFFSET, '0);
    chk("wake flag", 32'h4, rd & 32'h4);
    apb(1'b0, BAUD_CTRL_OFFSET, '0);
    chk("wake held", 32'h2, rd);
    u_peer.hold(1'b1, 2);
    apb(1'b0, BAUD_CTRL_OFFSET, '0);
    chk("wake cleared", 32'h0, rd);
    apb(1'b0, RX_DATA_OFFSET, '0);
    apb(1'b0, STATUS_OFFSET, '0);
    chk("flag cleared", 32'h0, rd & 32'h4);
  endtask : t_wake

  // Receiver bit is 13 units against 9 of the peer, so the break reads as one byte.
  task automatic t_rx_break;
    apb(1'b1, BAUD_OFFSET, 32'h67);
    apb(1'b1, CTRL_OFFSET, 32'h101);
    u_peer.hold(1'b0, 117);
    u_peer.hold(1'b1, 0);
    apb(1'b0, STATUS_OFFSET, '0);
    chk("break in progress", 32'h0, rd & 32'hC);
    repeat (80) @(posedge i_clk);
    apb(1'b0, STATUS_OFFSET, '0);
    chk("break received", 32'hC, rd & 32'hC);
    apb(1'b0, RX_DATA_OFFSET, '0);
    chk("break data", 32'h0, rd);
    apb(1'b0, STATUS_OFFSET, '0);
    chk("break flag read", 32'h0, rd & 32'h4);
  endtask : t_rx_break

  task automatic t_break;
    apb(1'b1, BAUD_OFFSET, 32'h010F);
    apb(1'b1, CTRL_OFFSET, 32'h19);
    fork
      begin
        u_peer.catch_async(14, fa);
        chk("break frame", 32'h2000, {18'h0, fa});
        u_peer.catch_async(10, fa);
        chk("sync frame", 32'h2AA, {18'h0, fa});
      end
      begin
        apb(1'b1, TX_DATA_OFFSET, 32'hFF);
        apb(1'b1, TX_DATA_OFFSET, 32'h55);
        apb(1'b0, STATUS_OFFSET, '0);
        chk("busy in break", 32'h0, rd & 32'h3);
      end
    join
    repeat (20) @(posedge i_clk);
    apb(1'b0, CTRL_OFFSET, '0);
    chk("break cleared", 32'h9, rd);
    apb(1'b0, STATUS_OFFSET, '0);
    chk("idle after break", 32'h3, rd & 32'h3);
  endtask : t_break

  task automatic t_clocked(input logic p);
    pol = p;
    apb(1'b1, BAUD_OFFSET, 32'h3);
    apb(1'b1, CTRL_OFFSET, {24'h0, p, 7'h6F});
    repeat (2) @(posedge i_clk);
    chk("clock idle", {30'h0, 1'b1, p}, {30'h0, ck_oe, ck_out});
    fork
      begin
        u_peer.catch_sync(9, fs);
        chk("word one", 32'h1A5, {23'h0, fs});
        u_peer.catch_sync(9, fs);
        chk("word two", 32'h13C, {23'h0, fs});
      end
      begin
        apb(1'b1, TX_DATA_OFFSET, 32'hA5);
        apb(1'b1, TX_DATA_OFFSET, 32'h3C);
        apb(1'b0, STATUS_OFFSET, '0);
        chk("word waiting", 32'h0, rd & 32'h3);
      end
    join
    repeat (20) @(posedge i_clk);
    chk("clock back idle", {31'h0, p}, {30'h0, dt_oe, ck_out});
    apb(1'b1, STATUS_OFFSET, 32'h0);
    apb(1'b0, STATUS_OFFSET, '0);
    chk("empty flags", 32'h3, rd & 32'h3);
  endtask : t_clocked

  // ==========================================================================
  // Sequence and watchdog
  initial begin
    req = '0;
    i_reset = 1'b1;
    pol = 1'b0;
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    t_reset;
    t_wake;
    t_rx_break;
    t_break;
    t_clocked(1'b0);
    t_clocked(1'b1);
    results;
  end

  // The full run needs under 3000 cycles; the ceiling leaves ample margin.
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      $display("[FAIL] run length expected below 5000 seen %0d", cyc);
      results;
    end
  end
endmodule : serial_break_and_sync_master_tx_bench
